/* File: core/decode_core.sv */
// instruction fetch, decode and load/store sequencer of the 8-bit core
//
// Functional notes
// - set or clear any data-space bit in one instruction, old bit copied to carry.
// - branch to a target depending on any single data-space bit.
// - six-cell 12-bit return stack fed by calls and interrupt entry.
// - accumulator, pointer and short registers, peripherals and memory share one byte space.
// - immediate operand is the last program byte: right after the opcode, or after the address byte for register-immediate.
// - direct mode uses the byte after the opcode as a 256-byte data address.
// - short direct picks one of 80h..83h from an opcode field, no address byte.
// - extended mode joins opcode low nibble and next byte into a 12-bit target.
// - one-byte relative branches reach -15..+16, else fall through.
// - relative opcode is test in top three bits, direction bit, four-bit span.
// - bit direct takes bit number from opcode, address from next byte.
// - bit test branch is three bytes, signed displacement covers -127..+128.
// - indirect uses pointer at 80h or 81h, chosen by opcode bit 4.
// - inherent instructions are one byte and carry everything in the opcode.
// - opcodes decode into six groups across nine addressing modes.
// - loads move data between accumulator and operand; immediate load reaches any byte.
// - load/store takes four cycles, length by mode, zero updated except register-immediate.
module decode_core
	import core_pkg::*;
#(
	parameter logic [11:0] IRQ_ADDR = IRQ_VECTOR,
	parameter int STACK_DEPTH = 6
) (
	input wire logic clock_in,
	input wire logic rst_in,
	output logic [PC_W-1:0] prog_addr_out,
	input wire logic [7:0] prog_data_in,
	output logic [7:0] data_addr_out,
	output logic [7:0] data_wdata_out,
	output logic data_we_out,
	output logic data_re_out,
	input wire logic [7:0] data_rdata_in,
	input wire logic irq_in,
	output logic [7:0] acc_out,
	output logic zero_flag_out,
	output logic carry_flag_out,
	output logic [PC_W-1:0] pc_out,
	output logic illegal_out
);

	typedef struct packed {
		phase_type ph;
		logic [2:0] cyc;
		logic [2:0] need;
		logic [7:0] op;
		logic [7:0] b2;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] prog_addr;
		logic [7:0] data_addr;
		logic [7:0] wdata;
		logic we;
		logic re;
		logic [7:0] acc;
		logic [3:0][7:0] sregs;
		logic zf;
		logic cf;
		logic [2:0] irq_sync;
		logic pend;
		logic illegal;
	} core_state_type;

	localparam core_state_type STATE_RESET = '{ph: PH_FETCH, pc: RESET_PC, prog_addr: RESET_PC, default: '0};

	core_state_type s_r;
	core_state_type s_nxt;
	logic [7:0] rd;
	logic irq_edge;
	logic rel_take;
	logic push_c;
	logic pop_c;
	logic [PC_W-1:0] push_data_c;

	stack_port_if #(.WIDTH(PC_W)) stk ();

	return_stack #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.port(stk.store)
	);

	assign stk.push = push_c;
	assign stk.pop = pop_c;
	assign stk.push_data = push_data_c;

	// zero test shared by every zero-flag update
	function automatic logic is_zero(logic [7:0] v);
		return v == ZERO_BYTE;
	endfunction

	// internal registers answer their own addresses, everything else comes from outside
	function automatic logic [7:0] read_space(logic [7:0] a, logic [7:0] acc, logic [3:0][7:0] sr,
		logic [7:0] ext);
		if (a == ACC_ADDR) begin
			return acc;
		end else if (a[7:2] == SHORT_BASE[7:2]) begin
			return sr[a[1:0]];
		end
		return ext;
	endfunction

	// a write always goes out on the bus and also refreshes the internal copy if it hits one
	function automatic core_state_type put(core_state_type st, logic [7:0] a, logic [7:0] v);
		core_state_type r;
		r = st;
		r.data_addr = a;
		r.wdata = v;
		r.we = 1'b1;
		if (a == ACC_ADDR) begin
			r.acc = v;
		end
		if (a[7:2] == SHORT_BASE[7:2]) begin
			r.sregs[a[1:0]] = v;
		end
		return r;
	endfunction

	// wait out the instruction's cycle budget before fetching again
	function automatic phase_type done_phase(logic [2:0] cyc, logic [2:0] need);
		return (cyc >= need) ? PH_FETCH : PH_FINISH;
	endfunction

	// point the program counter and the fetch address at the next instruction
	function automatic core_state_type finish(core_state_type st, logic [PC_W-1:0] t);
		core_state_type r;
		r = st;
		r.pc = t;
		r.prog_addr = t;
		r.ph = done_phase(st.cyc, st.need);
		return r;
	endfunction

	// relative branch conditions on the flags
	always_comb begin
		unique case (s_r.op[7:5])
			REL_C: rel_take = s_r.cf;
			REL_NC: rel_take = !s_r.cf;
			REL_Z: rel_take = s_r.zf;
			default: rel_take = !s_r.zf;
		endcase
	end

	// only the second synchroniser stage and the history bit feed the edge detector
	assign irq_edge = s_r.irq_sync[1] && !s_r.irq_sync[2];

	// sequencer: one pass per cycle, all state in one struct
	always_comb begin
		rd = read_space(s_r.data_addr, s_r.acc, s_r.sregs, data_rdata_in);
		s_nxt = s_r;
		s_nxt.cyc = 3'(s_r.cyc + 3'h1);
		s_nxt.we = 1'b0;
		s_nxt.re = 1'b0;
		s_nxt.illegal = 1'b0;
		s_nxt.irq_sync = {s_r.irq_sync[1:0], irq_in};
		push_c = 1'b0;
		pop_c = 1'b0;
		push_data_c = '0;
		unique case (s_r.ph)
			PH_FETCH: begin
				if (s_r.pend) begin
					// interrupt entry only at an instruction boundary
					push_c = 1'b1;
					push_data_c = s_r.pc;
					s_nxt.pend = 1'b0;
					s_nxt.need = CYC_IRQ;
					s_nxt = finish(s_nxt, IRQ_ADDR);
				end else begin
					s_nxt.op = prog_data_in;
					s_nxt.prog_addr = PC_W'(s_r.pc + LEN1);
					s_nxt.ph = PH_DECODE;
				end
			end
			PH_DECODE: begin
				// prog_data_in now holds the byte after the opcode
				unique case (s_r.op[7:5])
					REL_C, REL_NC, REL_Z, REL_NZ: begin
						s_nxt.need = CYC_REL;
						if (!rel_take) begin
							s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1));
						end else if (s_r.op[OP_SEL_BIT]) begin
							s_nxt = finish(s_nxt, PC_W'(s_r.pc - {8'h00, s_r.op[3:0]}));
						end else begin
							s_nxt = finish(s_nxt, PC_W'(s_r.pc + {8'h00, s_r.op[3:0]} + LEN1));
						end
					end
					CLS_EXT: begin
						s_nxt.need = CYC_EXT;
						if (s_r.op[OP_SEL_BIT]) begin
							push_c = 1'b1;
							push_data_c = PC_W'(s_r.pc + LEN2);
						end
						s_nxt = finish(s_nxt, {s_r.op[3:0], prog_data_in});
					end
					CLS_BIT: begin
						// address byte selects the data byte, bit number stays in the opcode
						s_nxt.b2 = prog_data_in;
						s_nxt.data_addr = prog_data_in;
						s_nxt.re = 1'b1;
						s_nxt.prog_addr = PC_W'(s_r.pc + LEN2);
						if (s_r.op[OP_SEL_BIT]) begin
							s_nxt.need = CYC_BTB;
							s_nxt.ph = PH_OPER;
						end else begin
							s_nxt.need = CYC_BIT;
							s_nxt.ph = PH_READ;
						end
					end
					CLS_LDST: begin
						s_nxt.need = CYC_LDST;
						if (!s_r.op[OP_SEL_BIT]) begin
							// short direct: register picked from the opcode, one byte
							if (s_r.op[OP_MODE_BIT]) begin
								s_nxt = put(s_nxt, SHORT_BASE | {6'h00, s_r.op[1:0]}, s_r.acc);
								s_nxt.zf = is_zero(s_r.acc);
							end else begin
								s_nxt.acc = s_r.sregs[s_r.op[1:0]];
								s_nxt.zf = is_zero(s_r.sregs[s_r.op[1:0]]);
							end
							s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1));
						end else begin
							case (s_r.op[3:0])
								SUB_LD_A_DIR: begin
									s_nxt.data_addr = prog_data_in;
									s_nxt.re = 1'b1;
									s_nxt.ph = PH_READ;
								end
								SUB_LD_DIR_A: begin
									s_nxt = put(s_nxt, prog_data_in, s_r.acc);
									s_nxt.zf = is_zero(s_r.acc);
									s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN2));
								end
								SUB_LDI_A: begin
									s_nxt.acc = prog_data_in;
									s_nxt.zf = is_zero(prog_data_in);
									s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN2));
								end
								SUB_LDI_DIR: begin
									s_nxt.b2 = prog_data_in;
									s_nxt.prog_addr = PC_W'(s_r.pc + LEN2);
									s_nxt.ph = PH_OPER;
								end
								SUB_NOP: begin
									s_nxt.need = CYC_CTL;
									s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1));
								end
								SUB_RET: begin
									s_nxt.need = CYC_CTL;
									pop_c = 1'b1;
									s_nxt = finish(s_nxt, stk.top_data);
								end
								default: begin
									// unexecuted codes cost a control slot and are flagged
									s_nxt.illegal = 1'b1;
									s_nxt.need = CYC_CTL;
									s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1));
								end
							endcase
						end
					end
					CLS_IND: begin
						s_nxt.need = CYC_LDST;
						if (s_r.op[OP_MODE_BIT]) begin
							s_nxt = put(s_nxt, s_r.op[OP_SEL_BIT] ? s_r.sregs[1] : s_r.sregs[0], s_r.acc);
							s_nxt.zf = is_zero(s_r.acc);
							s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1));
						end else begin
							s_nxt.data_addr = s_r.op[OP_SEL_BIT] ? s_r.sregs[1] : s_r.sregs[0];
							s_nxt.re = 1'b1;
							s_nxt.ph = PH_READ;
						end
					end
				endcase
			end
			PH_OPER: begin
				// third program byte is on prog_data_in
				if (s_r.op[7:5] == CLS_BIT) begin
					s_nxt.cf = rd[s_r.op[2:0]];
					if (rd[s_r.op[2:0]] == s_r.op[OP_MODE_BIT]) begin
						s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN1 + {{4{prog_data_in[7]}}, prog_data_in}));
					end else begin
						s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN3));
					end
				end else begin
					// register-immediate leaves both flags alone
					s_nxt = put(s_nxt, s_r.b2, prog_data_in);
					s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN3));
				end
			end
			PH_READ: begin
				if (s_r.op[7:5] == CLS_BIT) begin
					// read-modify-write of one bit, old value into carry
					s_nxt.cf = rd[s_r.op[2:0]];
					s_nxt = put(s_nxt, s_r.data_addr, (rd & ~(8'h01 << s_r.op[2:0])) |
						({7'h00, s_r.op[OP_MODE_BIT]} << s_r.op[2:0]));
					s_nxt = finish(s_nxt, PC_W'(s_r.pc + LEN2));
				end else begin
					s_nxt.acc = rd;
					s_nxt.zf = is_zero(rd);
					s_nxt = finish(s_nxt, (s_r.op[7:5] == CLS_IND) ? PC_W'(s_r.pc + LEN1) : PC_W'(s_r.pc + LEN2));
				end
			end
			PH_FINISH: begin
				s_nxt.ph = done_phase(s_nxt.cyc, s_r.need);
			end
			default: begin
				s_nxt.ph = PH_FETCH;
			end
		endcase
		if (s_nxt.ph == PH_FETCH) begin
			s_nxt.cyc = '0;
		end
		// a new request in the cycle the pending bit is taken is kept
		if (irq_edge) begin
			s_nxt.pend = 1'b1;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= STATE_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// every output is a field of the state register
	assign prog_addr_out = s_r.prog_addr;
	assign data_addr_out = s_r.data_addr;
	assign data_wdata_out = s_r.wdata;
	assign data_we_out = s_r.we;
	assign data_re_out = s_r.re;
	assign acc_out = s_r.acc;
	assign zero_flag_out = s_r.zf;
	assign carry_flag_out = s_r.cf;
	assign pc_out = s_r.pc;
	assign illegal_out = s_r.illegal;

	// checks of the documented sequencing
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	logic fetch_ldst;
	logic fetch_btb;
	logic fetch_rel;
	assign fetch_ldst = (s_r.ph == PH_FETCH) && !s_r.pend && ((prog_data_in[7:5] == CLS_IND) ||
		((prog_data_in[7:5] == CLS_LDST) && (!prog_data_in[OP_SEL_BIT] || prog_data_in[3:0] <= SUB_LDI_DIR)));
	assign fetch_btb = (s_r.ph == PH_FETCH) && !s_r.pend && (prog_data_in[7:4] == {CLS_BIT, 1'b1});
	assign fetch_rel = (s_r.ph == PH_FETCH) && !s_r.pend && !prog_data_in[7];

	sequence seq_four_cycle_end;
		##1 (s_r.ph != PH_FETCH) [*3] ##1 (s_r.ph == PH_FETCH);
	endsequence

	sequence seq_carry_held;
		##1 $stable(s_r.cf) [*4];
	endsequence

	a_ldst_four_cycles: assert property (fetch_ldst |-> seq_four_cycle_end)
		else $error("load/store did not take four cycles");

	a_ldst_carry_kept: assert property (fetch_ldst |-> seq_carry_held)
		else $error("load/store changed carry");

	a_rel_two_cycles: assert property (fetch_rel |-> ##2 (s_r.ph == PH_FETCH))
		else $error("relative branch did not take two cycles");

	a_rel_back_target: assert property ((s_r.ph == PH_DECODE) && !s_r.op[7] && s_r.op[OP_SEL_BIT] && rel_take
		|=> s_r.pc == PC_W'($past(s_r.pc) - {8'h00, $past(s_r.op[3:0])}))
		else $error("backward relative target wrong");

	a_btb_five_cycles: assert property (fetch_btb |-> ##5 (s_r.ph == PH_FETCH))
		else $error("bit test branch did not take five cycles");

	a_ext_target_join: assert property ((s_r.ph == PH_DECODE) && (s_r.op[7:5] == CLS_EXT)
		|=> s_r.pc == {$past(s_r.op[3:0]), $past(prog_data_in)})
		else $error("extended target wrong");

	a_bit_carry_write: assert property ((s_r.ph == PH_READ) && (s_r.op[7:5] == CLS_BIT)
		|=> s_r.we && (s_r.cf == $past(rd[s_r.op[2:0]])) && (s_r.wdata[s_r.op[2:0]] == s_r.op[OP_MODE_BIT]))
		else $error("bit set/clear or carry copy wrong");

	a_ind_pointer_sel: assert property ((s_r.ph == PH_DECODE) && (s_r.op[7:5] == CLS_IND)
		|=> s_r.data_addr == ($past(s_r.op[OP_SEL_BIT]) ? $past(s_r.sregs[1]) : $past(s_r.sregs[0])))
		else $error("indirect pointer not selected by bit 4");

	a_direct_load_acc: assert property ((s_r.ph == PH_DECODE) && (s_r.op[7:4] == {CLS_LDST, 1'b1}) &&
		(s_r.op[3:0] == SUB_LD_A_DIR) |=> (s_r.re && s_r.data_addr == $past(prog_data_in))
		##1 (s_r.acc == $past(rd) && s_r.zf == ($past(rd) == ZERO_BYTE)))
		else $error("direct load did not use the address byte");

	a_imm_acc_zero: assert property ((s_r.ph == PH_DECODE) && (s_r.op[7:4] == {CLS_LDST, 1'b1}) &&
		(s_r.op[3:0] == SUB_LDI_A) |=> s_r.acc == $past(prog_data_in) && s_r.zf == (s_r.acc == ZERO_BYTE))
		else $error("immediate load wrong");

	a_ldi_reg_zero_kept: assert property ((s_r.ph == PH_DECODE) && (s_r.op[7:4] == {CLS_LDST, 1'b1}) &&
		(s_r.op[3:0] == SUB_LDI_DIR) |=> $stable(s_r.zf) ##1 ($stable(s_r.zf) && s_r.we))
		else $error("register-immediate load touched zero");

endmodule

/* File: core/core_pkg.sv */
// shared constants, opcode fields and phase codes of the fetch and decode core
package core_pkg;

	// program counter width: 4K program space
	localparam int PC_W = 12;

	// data space map
	localparam logic [7:0] ACC_ADDR = 8'hff;
	localparam logic [7:0] SHORT_BASE = 8'h80;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// entry and interrupt addresses
	localparam logic [11:0] RESET_PC = 12'h000;
	localparam logic [11:0] IRQ_VECTOR = 12'hff0;

	// instruction lengths in program bytes
	localparam logic [11:0] LEN1 = 12'h001;
	localparam logic [11:0] LEN2 = 12'h002;
	localparam logic [11:0] LEN3 = 12'h003;

	// cycles per instruction class
	localparam logic [2:0] CYC_LDST = 3'h4;
	localparam logic [2:0] CYC_REL = 3'h2;
	localparam logic [2:0] CYC_CTL = 3'h2;
	localparam logic [2:0] CYC_EXT = 3'h4;
	localparam logic [2:0] CYC_BIT = 3'h4;
	localparam logic [2:0] CYC_BTB = 3'h5;
	localparam logic [2:0] CYC_IRQ = 3'h2;

	// opcode bits 7..5: relative tests and the other classes
	localparam logic [2:0] REL_C = 3'h0;
	localparam logic [2:0] REL_NC = 3'h1;
	localparam logic [2:0] REL_Z = 3'h2;
	localparam logic [2:0] REL_NZ = 3'h3;
	localparam logic [2:0] CLS_EXT = 3'h4;
	localparam logic [2:0] CLS_BIT = 3'h5;
	localparam logic [2:0] CLS_LDST = 3'h6;
	localparam logic [2:0] CLS_IND = 3'h7;

	// single-bit fields of the opcode
	localparam int OP_SEL_BIT = 4;
	localparam int OP_MODE_BIT = 3;

	// low nibble sub-codes when the class is load/store and bit 4 is set
	localparam logic [3:0] SUB_LD_A_DIR = 4'h0;
	localparam logic [3:0] SUB_LD_DIR_A = 4'h1;
	localparam logic [3:0] SUB_LDI_A = 4'h2;
	localparam logic [3:0] SUB_LDI_DIR = 4'h3;
	localparam logic [3:0] SUB_NOP = 4'h4;
	localparam logic [3:0] SUB_RET = 4'h5;

	// sequencer phases, gray along fetch, decode, operand, read, finish
	typedef enum logic [2:0] {
		PH_FETCH = 3'h0,
		PH_DECODE = 3'h1,
		PH_OPER = 3'h3,
		PH_READ = 3'h2,
		PH_FINISH = 3'h6
	} phase_type;

endpackage

/* File: core/stack_port_if.sv */
// push and pop port between the sequencer and the return address stack
interface stack_port_if #(parameter int WIDTH = 12);
	logic push;
	logic pop;
	logic [WIDTH-1:0] push_data;
	logic [WIDTH-1:0] top_data;
	logic full;
	logic empty;

	modport owner (output push, output pop, output push_data, input top_data, input full, input empty);
	modport store (input push, input pop, input push_data, output top_data, output full, output empty);
endinterface

/* File: core/return_stack.sv */
// return address stack with a registered top-of-stack word
module return_stack #(
	parameter int DEPTH = 6,
	parameter int WIDTH = 12
) (
	input wire logic clock_in,
	input wire logic rst_in,
	stack_port_if.store port
);
	localparam int SP_W = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] cells;
		logic [SP_W-1:0] sp;
		logic [WIDTH-1:0] top;
	} stack_state_type;

	stack_state_type s_r;
	stack_state_type s_nxt;
	logic full;
	logic empty;

	assign full = (s_r.sp == SP_W'(DEPTH));
	assign empty = (s_r.sp == '0);
	assign port.full = full;
	assign port.empty = empty;
	assign port.top_data = s_r.top;

	// push wins over pop unless the stack is full; overflow drops the new word rather than corrupting older ones
	always_comb begin
		s_nxt = s_r;
		if (port.push && !full) begin
			s_nxt.cells[s_r.sp] = port.push_data;
			s_nxt.sp = SP_W'(s_r.sp + SP_W'(1));
			s_nxt.top = port.push_data;
		end else if (port.pop && !empty) begin
			s_nxt.sp = SP_W'(s_r.sp - SP_W'(1));
			s_nxt.top = (s_r.sp >= SP_W'(2)) ? s_r.cells[SP_W'(s_r.sp - SP_W'(2))] : '0;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// a push lands on top and deepens the stack by one
	a_stack_push_top: assert property (@(posedge clock_in) disable iff (rst_in)
		(port.push && !full) |=> (s_r.top == $past(port.push_data)) && (s_r.sp == SP_W'($past(s_r.sp) + 1)))
		else $error("stack push did not land on top");
endmodule

/* File: verif/prog_data_space_model.sv */
// program memory and 256-byte data space seen by the core
module prog_data_space_model
	import core_pkg::*;
(
	input wire logic clock_in,
	input wire logic [PC_W-1:0] prog_addr_in,
	output logic [7:0] prog_data_out,
	input wire logic [7:0] data_addr_in,
	input wire logic [7:0] data_wdata_in,
	input wire logic data_we_in,
	output logic [7:0] data_rdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rom [0:4095];
	logic [7:0] ram [0:255];

	// both memories answer in the same cycle, since the core inserts no wait state
	assign prog_data_out = rom[prog_addr_in];
	assign data_rdata_out = ram[data_addr_in];

	// byte writes land on the edge that sees the strobe
	always @(posedge clock_in) begin
		if (data_we_in === 1'b1)
			ram[data_addr_in] <= data_wdata_in;
	end
endmodule

/* File: verif/test_core_addressing_load_store_decode.sv */
// testbench: loads short programs, runs the core and judges what it does
module test_core_addressing_load_store_decode
	import core_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic irq_in = 1'b0;
	logic [PC_W-1:0] prog_addr;
	logic [PC_W-1:0] pc_out;
	logic [7:0] prog_data;
	logic [7:0] data_addr;
	logic [7:0] data_wdata;
	logic [7:0] data_rdata;
	logic [7:0] acc_out;
	logic data_we;
	logic data_re;
	logic zero_flag_out;
	logic carry_flag_out;
	logic illegal_out;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int n_ill = 0;
	int n_rd = 0;

	decode_core DUT (.clock_in(clock_in), .rst_in(rst_in), .prog_addr_out(prog_addr), .prog_data_in(prog_data),
		.data_addr_out(data_addr), .data_wdata_out(data_wdata), .data_we_out(data_we), .data_re_out(data_re),
		.data_rdata_in(data_rdata), .irq_in(irq_in), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
		.carry_flag_out(carry_flag_out), .pc_out(pc_out), .illegal_out(illegal_out));

	prog_data_space_model mem (.clock_in(clock_in), .prog_addr_in(prog_addr), .prog_data_out(prog_data),
		.data_addr_in(data_addr), .data_wdata_in(data_wdata), .data_we_in(data_we), .data_rdata_out(data_rdata));

	// clock, cycle stamp and tallies of unexecuted-opcode and read-strobe pulses
	always #4 clock_in = ~clock_in;
	always @(posedge clock_in) cyc <= cyc + 1;
	always @(posedge clock_in) begin
		if (illegal_out === 1'b1)
			n_ill <= n_ill + 1;
		if (data_re === 1'b1)
			n_rd <= n_rd + 1;
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// reset held while memories are wiped; unused program bytes read as no-op
	task automatic hold();
		@(posedge clock_in);
		rst_in <= 1'b1;
		@(posedge clock_in);
		for (int i = 0; i < 4096; i++)
			mem.rom[i] = 8'hd4;
		for (int i = 0; i < 256; i++)
			mem.ram[i] = 8'h00;
	endtask

	task automatic go();
		@(posedge clock_in);
		rst_in <= 1'b0;
	endtask

	task automatic put(input logic [11:0] a, input logic [7:0] q[$]);
		foreach (q[i])
			mem.rom[a + 12'(i)] = q[i];
	endtask

	// waits for the core to reach an address, stamps it, then lets effects settle
	task automatic at_pc(input logic [11:0] a, output int t, input int s);
		int n;
		n = 0;
		while (pc_out !== a && n < 300) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		t = cyc;
		chk(pc_out, a);
		repeat (s) @(posedge clock_in);
		#1;
	endtask

	// loads and stores through immediate, direct, short direct and indirect forms
	// the program counter moves when an instruction resolves its target, so cycle counts are
	// taken between instructions that resolve at the same step
	task automatic ld_store();
		int t0;
		int t1;
		int k;
		hold();
		put(12'h000, {8'hd2, 8'h00, 8'hd3, 8'h41, 8'ha5, 8'hd2, 8'h5a, 8'hd1, 8'h40, 8'hd0, 8'h42});
		put(12'h00b, {8'hd2, 8'h60, 8'hc8, 8'hd2, 8'h00, 8'he0, 8'hc9, 8'hf8, 8'hd2, 8'h00, 8'hc1, 8'h80, 8'h16});
		mem.ram[8'h60] = 8'h3c;
		k = n_rd;
		go();
		at_pc(12'h002, t0, 2);
		chk(12'(acc_out), 12'h000);
		chk(12'(zero_flag_out), 12'h001);
		at_pc(12'h005, t1, 2);
		chk(12'(mem.ram[8'h41]), 12'h0a5);
		chk(12'(zero_flag_out), 12'h001);
		at_pc(12'h007, t1, 2);
		chk(12'(t1 - t0), 12'h008);
		chk(12'(zero_flag_out), 12'h000);
		at_pc(12'h009, t0, 2);
		chk(12'(t0 - t1), 12'h004);
		chk(12'(mem.ram[8'h40]), 12'h05a);
		at_pc(12'h00b, t0, 2);
		chk(12'(zero_flag_out), 12'h001);
		at_pc(12'h011, t0, 2);
		chk(12'(acc_out), 12'h03c);
		at_pc(12'h016, t0, 2);
		chk(12'(mem.ram[8'h3c]), 12'h03c);
		chk(12'(acc_out), 12'h03c);
		chk(12'(carry_flag_out), 12'h000);
		chk(12'(n_rd - k), 12'h002);
	endtask

	// set and clear of single bits, then bit tests at both ends of the displacement
	task automatic bit_ops();
		int t0;
		int t1;
		hold();
		put(12'h000, {8'ha8, 8'h50, 8'ha7, 8'h50, 8'hd0, 8'h42, 8'hb8, 8'h50, 8'h7f, 8'h80, 8'h0a});
		put(12'h086, {8'hb0, 8'h50, 8'h80, 8'hb1, 8'h50, 8'h80});
		mem.ram[8'h50] = 8'h80;
		go();
		at_pc(12'h002, t0, 2);
		chk(12'(mem.ram[8'h50]), 12'h081);
		chk(12'(carry_flag_out), 12'h000);
		at_pc(12'h004, t0, 2);
		chk(12'(mem.ram[8'h50]), 12'h001);
		chk(12'(carry_flag_out), 12'h001);
		at_pc(12'h006, t0, 2);
		chk(12'(carry_flag_out), 12'h001);
		at_pc(12'h086, t0, 2);
		chk(12'(carry_flag_out), 12'h001);
		at_pc(12'h089, t1, 2);
		chk(12'(t1 - t0), 12'h005);
		at_pc(12'h00a, t0, 2);
		chk(12'(carry_flag_out), 12'h000);
	endtask

	// relative tests on every condition, long call and return, inherent codes
	task automatic branch_flow();
		int t0;
		int t1;
		int k;
		hold();
		put(12'h000, {8'hd2, 8'h00, 8'h4f, 8'h00, 8'h23});
		put(12'h008, {8'h0f, 8'h9a, 8'hbc, 8'h8f, 8'h00});
		put(12'h012, {8'h6f, 8'h5f});
		put(12'habc, {8'hd6, 8'hd4, 8'hd5});
		put(12'hf00, {8'h8f, 8'h00});
		k = n_ill;
		go();
		at_pc(12'h002, t0, 0);
		at_pc(12'h012, t0, 0);
		at_pc(12'h013, t1, 0);
		chk(12'(t1 - t0), 12'h002);
		at_pc(12'h004, t0, 0);
		at_pc(12'h008, t0, 0);
		at_pc(12'h009, t0, 0);
		at_pc(12'habc, t0, 0);
		at_pc(12'habd, t0, 0);
		at_pc(12'habe, t0, 0);
		at_pc(12'h00b, t0, 0);
		at_pc(12'hf00, t0, 2);
		chk(12'(n_ill - k), 12'h001);
	endtask

	// an interrupt edge during a tight loop must stack the loop address; the return proves it
	task automatic irq_entry();
		int t0;
		hold();
		put(12'h000, {8'h80, 8'h08});
		put(12'h008, {8'h80, 8'h08});
		put(IRQ_VECTOR, {8'hd5});
		go();
		repeat (4) @(posedge clock_in);
		irq_in <= 1'b1;
		at_pc(IRQ_VECTOR, t0, 3);
		chk(pc_out, 12'h008);
		@(posedge clock_in);
		irq_in <= 1'b0;
	endtask

	// the whole run takes well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock_in);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (16) @(posedge clock_in);
		ld_store();
		bit_ops();
		branch_flow();
		irq_entry();
		close_out();
	end
endmodule
